// ===== hw/timer3_defines.svh
/*
 * register offsets, field positions, reset values and constants
 * for the sixteen-bit timer/counter. assumes a 32-bit axi4-lite slave,
 * one register per aligned word.
 */
`ifndef TIMER3_DEFINES_SVH
`define TIMER3_DEFINES_SVH

// ==========================================================
// register byte offsets
`define OFF_TIMER3_CONTROL        12'h000
`define OFF_TIMER3_COUNT_LOW      12'h004
`define OFF_TIMER3_COUNT_HIGH     12'h008
`define OFF_PERIPH_IRQ_FLAGS2     12'h00C
`define OFF_PERIPH_IRQ_ENABLE2    12'h010
`define OFF_PERIPH_IRQ_PRIORITY2  12'h014
`define OFF_TIMER1_CONTROL        12'h018

// ==========================================================
// control and irq field positions
`define BIT_COUNTER_ON            0
`define BIT_CLOCK_SOURCE_SELECT   1
`define BIT_EXTERNAL_SYNC_DISABLE 2
`define BIT_COMPARE_SEL_LO        3
`define BIT_PRESCALE_LO           4
`define BIT_COMPARE_SEL_HI        6
`define BIT_WIDE_ACCESS_ENABLE    7
`define BIT_OVERFLOW_IRQ          1
`define BIT_LOWPOWER_OSC_ENABLE   3

// ==========================================================
// reset values and constants
`define RST_CONTROL               8'h00
`define RST_IRQ_REG               8'h00
`define RST_TIMER1_CONTROL        8'h00
`define COUNT_ALL_ONES            16'hFFFF
`define SPECIAL_EVENT_MODE        4'hB
`define AXI_RESP_OKAY             2'h0
`define AXI_RESP_SLVERR           2'h2

`endif

// ===== hw/timer3_pkg.sv
/*
 * types shared by the timer/counter files.
 * assumes the defines header is included by users that need numbers.
 */
package timer3_pkg;
    // ==========================================================
    // prescale ratios
    typedef enum logic [1:0] {
        PRE_DIV1 = 2'h0,
        PRE_DIV2 = 2'h1,
        PRE_DIV4 = 2'h2,
        PRE_DIV8 = 2'h3
    } prescale_t;

    // ==========================================================
    // read channel states, gray along idle->answer
    typedef enum logic [0:0] {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } rd_state_t;
endpackage

// ===== hw/clk_edge_select.sv
/*
 * picks the count event for the counter: instruction-cycle tick, or a
 * rising edge of the external clock, synchronised or not.
 * assumes extClk is a level sampled on core_clk.
 */
`timescale 1ns/1ns
module clk_edge_select (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic sys_rst,
    // configuration
    input  wire logic clockSourceSelect,
    input  wire logic externalSyncDisable,
    input  wire logic lowpowerOscEnable,
    // clock sources
    input  wire logic extClk,
    input  wire logic oscClk,
    // count event
    output logic      countTick
);
    logic srcLevel;
    logic sync1_r;
    logic sync2_r;
    logic prev_r;
    logic armed_r;
    logic useLevel;
    logic rise;

    // oscillator only chosen while its enable is set
    assign srcLevel = lowpowerOscEnable ? oscClk : extClk;

    // two-stage synchroniser; first stage read only by second
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= srcLevel;
            sync2_r <= sync1_r;
        end
    end

    // unsynchronised path skips the two-stage delay
    assign useLevel = externalSyncDisable ? srcLevel : sync2_r;

    // edge history; armed only after a falling edge is seen
    // history rests at the pin's idle low, so selecting the source never fakes a fall
    always_ff @(posedge core_clk) begin
        if (sys_rst || !clockSourceSelect) begin
            prev_r  <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            prev_r <= useLevel;
            if (prev_r && !useLevel)
                armed_r <= 1'b1;
        end
    end

    assign rise = armed_r && !prev_r && useLevel;

    // internal source ticks every cycle, one instruction cycle here
    assign countTick = clockSourceSelect ? rise : 1'b1;
endmodule

// ===== hw/timer3_counter.sv
/*
 * sixteen-bit timer/counter with prescaler, wide access buffer,
 * special-event clear and compare-timer routing, on axi4-lite.
 * assumes core_clk is the instruction clock and the compare unit
 * drives its mode and trigger from outside.
 */
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "timer3_defines.svh"

module timer3_counter (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    // axi4-lite write
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // clock sources and pins
    input  wire logic        sharedExternalClockPin,
    input  wire logic        oscClk,
    input  wire logic [1:0]  portDirectionBits,
    output logic [1:0]       oscPinInputForce,
    // compare unit side
    input  wire logic [3:0]  compareUnitMode,
    input  wire logic        compareTrigger,
    input  wire logic [15:0] timer1Count,
    output logic [15:0]      compare1Timebase,
    output logic [15:0]      compare2Timebase,
    // interrupt request
    output logic             overflowIrq,
    output logic             overflowIrqHigh
);
    import timer3_pkg::*;

    logic [7:0]  control_r;
    logic [7:0]  irqFlags_r;
    logic [7:0]  irqEnable_r;
    logic [7:0]  irqPriority_r;
    logic [7:0]  timer1Control_r;
    logic [15:0] count_r;
    logic [15:0] count_nxt;
    logic [7:0]  highBuf_r;
    logic [2:0]  prescale_r;
    logic        countTick;
    logic        preDone;
    logic        step;
    logic        wrLow;
    logic        wrHigh;
    logic        wrFire;
    logic        awHeld_r;
    logic        wHeld_r;
    logic [11:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0]  wStrb_r;
    logic        wideMode;
    logic        trigClear;
    rd_state_t   rdState_r;

    // ==========================================================
    // helpers
    function automatic logic [2:0] prescale_mask(input prescale_t sel);
        case (sel)
            PRE_DIV1: prescale_mask = 3'h0;
            PRE_DIV2: prescale_mask = 3'h1;
            PRE_DIV4: prescale_mask = 3'h3;
            PRE_DIV8: prescale_mask = 3'h7;
            default:  prescale_mask = 3'h0;
        endcase
    endfunction

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
        is_addr = (a == off);
    endfunction

    assign wideMode = control_r[`BIT_WIDE_ACCESS_ENABLE];

    // ==========================================================
    // write channel: address and data taken in either order
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign wrFire        = awHeld_r && wHeld_r && !s_axi_bvalid;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awAddr_r <= 12'h000;
            wData_r  <= 32'h0000_0000;
            wStrb_r  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end else if (wrFire) begin
                awHeld_r <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end else if (wrFire) begin
                wHeld_r <= 1'b0;
            end
        end
    end

    // response after both halves are in; unmapped gets slverr
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_RESP_OKAY;
        end else if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_r > `OFF_TIMER1_CONTROL || awAddr_r[1:0] != 2'h0)
                            ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign wrLow  = wrFire && wStrb_r[0] && is_addr(awAddr_r, `OFF_TIMER3_COUNT_LOW);
    assign wrHigh = wrFire && wStrb_r[0] && is_addr(awAddr_r, `OFF_TIMER3_COUNT_HIGH);

    // ==========================================================
    // control registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            control_r       <= `RST_CONTROL;
            irqEnable_r     <= `RST_IRQ_REG;
            irqPriority_r   <= `RST_IRQ_REG;
            timer1Control_r <= `RST_TIMER1_CONTROL;
        end else if (wrFire && wStrb_r[0]) begin
            if (is_addr(awAddr_r, `OFF_TIMER3_CONTROL))
                control_r <= wData_r[7:0];
            if (is_addr(awAddr_r, `OFF_PERIPH_IRQ_ENABLE2))
                irqEnable_r <= wData_r[7:0];
            if (is_addr(awAddr_r, `OFF_PERIPH_IRQ_PRIORITY2))
                irqPriority_r <= wData_r[7:0];
            if (is_addr(awAddr_r, `OFF_TIMER1_CONTROL))
                timer1Control_r <= wData_r[7:0];
        end
    end

    // ==========================================================
    // count event source
    clk_edge_select u_edge (
        .core_clk            (core_clk),
        .sys_rst             (sys_rst),
        .clockSourceSelect   (control_r[`BIT_CLOCK_SOURCE_SELECT]),
        .externalSyncDisable (control_r[`BIT_EXTERNAL_SYNC_DISABLE]),
        .lowpowerOscEnable   (timer1Control_r[`BIT_LOWPOWER_OSC_ENABLE]),
        .extClk              (sharedExternalClockPin),
        .oscClk              (oscClk),
        .countTick           (countTick)
    );

    // oscillator enable overrides the port direction bits
    assign oscPinInputForce = timer1Control_r[`BIT_LOWPOWER_OSC_ENABLE]
                              ? 2'h3 : portDirectionBits;

    // ==========================================================
    // prescaler; held while off so the phase is kept
    assign preDone = (prescale_r & prescale_mask(prescale_t'(control_r[5:4])))
                     == prescale_mask(prescale_t'(control_r[5:4]));
    assign step    = control_r[`BIT_COUNTER_ON] && countTick && preDone;

    always_ff @(posedge core_clk) begin
        if (sys_rst || wrLow) begin
            prescale_r <= 3'h0;
        end else if (control_r[`BIT_COUNTER_ON] && countTick) begin
            prescale_r <= preDone ? 3'h0 : prescale_r + 3'h1;
        end
    end

    // ==========================================================
    // counter: write beats trigger, trigger beats increment
    assign trigClear = compareTrigger && (compareUnitMode == `SPECIAL_EVENT_MODE);

    always_comb begin
        count_nxt = count_r;
        if (wrLow) begin
            count_nxt = wideMode ? {highBuf_r, wData_r[7:0]}
                                 : {count_r[15:8], wData_r[7:0]};
        end else if (wrHigh && !wideMode) begin
            count_nxt = {wData_r[7:0], count_r[7:0]};
        end else if (trigClear) begin
            count_nxt = 16'h0000;
        end else if (step) begin
            count_nxt = count_r + 16'h0001;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst)
            count_r <= 16'h0000;
        else
            count_r <= count_nxt;
    end

    // overflow only from a real wrap, never from a trigger clear
    logic wrapEvent;
    assign wrapEvent = step && !wrLow && !(wrHigh && !wideMode) && !trigClear
                       && (count_r == `COUNT_ALL_ONES);

    // flag register; hardware set wins over software clear
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            irqFlags_r <= `RST_IRQ_REG;
        else if (wrFire && wStrb_r[0] && is_addr(awAddr_r, `OFF_PERIPH_IRQ_FLAGS2))
            irqFlags_r <= wData_r[7:0] | {6'h00, wrapEvent, 1'b0};
        else if (wrapEvent)
            irqFlags_r[`BIT_OVERFLOW_IRQ] <= 1'b1;
    end

    // enable gates the flag; priority picks the line
    logic irqActive;
    assign irqActive       = irqFlags_r[`BIT_OVERFLOW_IRQ] && irqEnable_r[`BIT_OVERFLOW_IRQ];
    assign overflowIrq     = irqActive && !irqPriority_r[`BIT_OVERFLOW_IRQ];
    assign overflowIrqHigh = irqActive && irqPriority_r[`BIT_OVERFLOW_IRQ];

    // ==========================================================
    // compare unit timebase routing
    assign compare1Timebase = control_r[`BIT_COMPARE_SEL_HI] ? count_r : timer1Count;
    assign compare2Timebase = (control_r[`BIT_COMPARE_SEL_HI] || control_r[`BIT_COMPARE_SEL_LO])
                              ? count_r : timer1Count;

    // ==========================================================
    // read channel; one read under way, answer one cycle later
    assign s_axi_arready = (rdState_r == RD_IDLE);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rdState_r <= RD_IDLE;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `AXI_RESP_OKAY;
        end else begin
            case (rdState_r)
                RD_IDLE: begin
                    if (s_axi_arvalid) begin
                        rdState_r   <= RD_RESP;
                        s_axi_rresp <= `AXI_RESP_OKAY;
                        case (s_axi_araddr)
                            `OFF_TIMER3_CONTROL:       s_axi_rdata <= {24'h0, control_r};
                            `OFF_TIMER3_COUNT_LOW:     s_axi_rdata <= {24'h0, count_r[7:0]};
                            `OFF_TIMER3_COUNT_HIGH:    s_axi_rdata <= {24'h0, wideMode ? highBuf_r : count_r[15:8]};
                            `OFF_PERIPH_IRQ_FLAGS2:    s_axi_rdata <= {24'h0, irqFlags_r};
                            `OFF_PERIPH_IRQ_ENABLE2:   s_axi_rdata <= {24'h0, irqEnable_r};
                            `OFF_PERIPH_IRQ_PRIORITY2: s_axi_rdata <= {24'h0, irqPriority_r};
                            `OFF_TIMER1_CONTROL:       s_axi_rdata <= {24'h0, timer1Control_r};
                            default: begin
                                s_axi_rdata <= 32'h0000_0000;
                                s_axi_rresp <= `AXI_RESP_SLVERR;
                            end
                        endcase
                    end
                end
                RD_RESP: begin
                    if (s_axi_rready)
                        rdState_r <= RD_IDLE;
                end
                default: rdState_r <= RD_IDLE;
            endcase
        end
    end
    assign s_axi_rvalid = (rdState_r == RD_RESP);

    // high-byte buffer: low read latches, high write loads in wide mode
    always_ff @(posedge core_clk) begin
        if (sys_rst)
            highBuf_r <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready && is_addr(s_axi_araddr, `OFF_TIMER3_COUNT_LOW))
            highBuf_r <= count_r[15:8];
        else if (wrHigh && wideMode)
            highBuf_r <= wData_r[7:0];
    end

    // ==========================================================
    // checks
    chk_wrap_sets_flag: assert property (@(posedge core_clk) disable iff (sys_rst)
        (step && !trigClear && !wrLow && !wrHigh && count_r == 16'hFFFF) |=> (count_r == 16'h0000 && irqFlags_r[1]))
        else $error("wrap did not clear count and set flag");
    chk_off_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!control_r[0] && !wrLow && !wrHigh && !trigClear) |=> $stable(count_r))
        else $error("count moved while off");
    chk_trig_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
        (trigClear && !wrLow && !wrHigh) |=> (count_r == 16'h0000))
        else $error("trigger did not clear count");
    chk_trig_noflag: assert property (@(posedge core_clk) disable iff (sys_rst)
        (trigClear && !irqFlags_r[1] && !wrFire) |=> !irqFlags_r[1])
        else $error("trigger set overflow flag");
    chk_write_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wrLow && trigClear && !wideMode) |=> (count_r[7:0] == $past(wData_r[7:0])))
        else $error("trigger beat software write");
    chk_wide_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        (wrLow && wideMode) |=> (count_r == {$past(highBuf_r), $past(wData_r[7:0])}))
        else $error("wide write did not load buffer");
    chk_prescale_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        wrLow |=> (prescale_r == 3'h0))
        else $error("low write left prescaler");
    chk_internal_rate: assert property (@(posedge core_clk) disable iff (sys_rst)
        (control_r[0] && !control_r[1] && control_r[5:4] == 2'h0 && !wrLow && !(wrHigh && !wideMode) && !trigClear)
        |=> (count_r == $past(count_r) + 16'h0001))
        else $error("internal rate wrong");
    chk_route_cmp1: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!control_r[6]) |-> (compare1Timebase == timer1Count))
        else $error("compare one routing wrong");
    chk_osc_pins: assert property (@(posedge core_clk) disable iff (sys_rst)
        timer1Control_r[3] |-> (oscPinInputForce == 2'h3))
        else $error("osc pins not forced to input");
endmodule

// ===== bench/ext_clock_model.sv
/*
 * far-side clock sources: the shared external count pin and the
 * low-power oscillator. assumes the bench calls burst() between edges.
 */
`timescale 1ns/1ns
module ext_clock_model (
    // clock
    input  wire logic core_clk,
    // clock outputs
    output logic      pinClk,
    output logic      oscClk
);
    // ==========================================================
    // lines rest low between bursts, like a gated source at idle
    initial begin
        pinClk = 1'b0;
        oscClk = 1'b0;
    end

    // slow pulses, six core cycles each, so a synchroniser can follow
    task automatic burst(input int n, input bit useOsc);
        for (int i = 0; i < n; i++) begin
            repeat (3) @(posedge core_clk);
            if (useOsc) begin
                oscClk <= 1'b1;
            end else begin
                pinClk <= 1'b1;
            end
            repeat (3) @(posedge core_clk);
            oscClk <= 1'b0;
            pinClk <= 1'b0;
        end
    endtask
endmodule

// ===== bench/timer3_counter_test.sv
/*
 * self-checking bench for the timer/counter over axi4-lite.
 * assumes the defines header and package are compiled first.
 */
`timescale 1ns/1ns
`include "timer3_defines.svh"
module timer3_counter_test;
    import timer3_pkg::*;
    // ==========================================================
    // signals
    // response readies stay high, so back-to-back calls never drive them twice in one step
    logic        core_clk, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, overflowIrq, overflowIrqHigh, compareTrigger = 1'b0;
    logic        sharedExternalClockPin, oscClk;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF, compareUnitMode = 4'h0;
    logic [1:0]  s_axi_bresp, s_axi_rresp, portDirectionBits = 2'b00, oscPinInputForce, br, rr;
    logic [15:0] timer1Count = 16'h0000, compare1Timebase, compare2Timebase;
    logic [7:0]  rv, hold;
    int          n_fail = 0, comparisons = 0;
    localparam logic [11:0] CTL = `OFF_TIMER3_CONTROL, LO = `OFF_TIMER3_COUNT_LOW, HI = `OFF_TIMER3_COUNT_HIGH;
    localparam logic [11:0] FLG = `OFF_PERIPH_IRQ_FLAGS2, ENA = `OFF_PERIPH_IRQ_ENABLE2;
    localparam logic [11:0] PRI = `OFF_PERIPH_IRQ_PRIORITY2, T1C = `OFF_TIMER1_CONTROL;

    timer3_counter dut (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sharedExternalClockPin, .oscClk, .portDirectionBits, .oscPinInputForce, .compareUnitMode,
        .compareTrigger, .timer1Count, .compare1Timebase, .compare2Timebase, .overflowIrq, .overflowIrqHigh);
    ext_clock_model partner (.core_clk, .pinClk(sharedExternalClockPin), .oscClk);

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // ==========================================================
    // shared tasks; an unknown value always counts as a mismatch
    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi, input string m);
        comparisons++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h", $time, m, got);
        end
    endtask

    // trg pulses the trigger exactly on the edge where the write lands
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic trg = 1'b0);
        logic awp, wp;
        awp = 1'b1;
        wp = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (awp || wp) begin
            @(posedge core_clk);
            if (awp && s_axi_awready) begin
                awp = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (wp && s_axi_wready) begin
                wp = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        compareTrigger <= trg;
        @(posedge core_clk);
        compareTrigger <= 1'b0;
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        br = s_axi_bresp;
    endtask

    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        rv = s_axi_rdata[7:0];
        rr = s_axi_rresp;
    endtask

    task automatic wrap_up;
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs about a thousand cycles
    initial begin
        #400000;
        n_fail++;
        wrap_up();
    end

    // ==========================================================
    // test sequence
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            rd(12'(i == 0 ? 0 : 8 + 4 * i));
            chk(rv, 0, 0, "reset value");
        end
        rd(12'h020);
        chk(rr, `AXI_RESP_SLVERR, `AXI_RESP_SLVERR, "unmapped read");
        wr(12'h020, 8'h5A);
        chk(br, `AXI_RESP_SLVERR, `AXI_RESP_SLVERR, "unmapped write");
        // the low write clears the prescaler so each span starts in phase
        for (int p = 0; p < 4; p++) begin
            wr(CTL, 8'h00);
            wr(LO, 8'h00);
            wr(HI, 8'h00);
            wr(CTL, 8'(8'h01 | (p << 4)));
            repeat (64) @(posedge core_clk);
            wr(CTL, 8'h00);
            rd(LO);
            chk(rv, 16'(64 >> p), 16'((72 >> p) + 1), "prescaled count");
            hold = rv;
            repeat (10) @(posedge core_clk);
            rd(LO);
            chk(rv, hold, hold, "count held while off");
        end
        wr(HI, 8'hFF);
        wr(LO, 8'hF0);
        wr(CTL, 8'h01);
        repeat (40) @(posedge core_clk);
        wr(CTL, 8'h00);
        rd(FLG);
        chk(rv, 8'h02, 8'h02, "overflow flag");
        rd(HI);
        chk(rv, 0, 0, "wrapped high byte");
        chk(overflowIrq, 0, 0, "irq while disabled");
        wr(ENA, 8'h02);
        chk({overflowIrq, overflowIrqHigh}, 2, 2, "irq enabled");
        wr(PRI, 8'h02);
        chk({overflowIrq, overflowIrqHigh}, 1, 1, "irq high priority");
        wr(FLG, 8'h00);
        chk({overflowIrq, overflowIrqHigh}, 0, 0, "irq after clear");
        // triggers every 8 cycles clear the count before it can wrap
        compareUnitMode <= `SPECIAL_EVENT_MODE;
        wr(HI, 8'hFF);
        wr(LO, 8'hF0);
        wr(CTL, 8'h01);
        repeat (6) begin
            repeat (7) @(posedge core_clk);
            compareTrigger <= 1'b1;
            @(posedge core_clk);
            compareTrigger <= 1'b0;
        end
        wr(CTL, 8'h00);
        rd(FLG);
        chk(rv, 0, 0, "flag after trigger clears");
        rd(HI);
        chk(rv, 0, 0, "trigger clear");
        wr(HI, 8'h77);
        wr(LO, 8'h55, 1'b1);
        rd(LO);
        chk(rv, 8'h55, 8'h55, "write beats trigger");
        rd(HI);
        chk(rv, 8'h77, 8'h77, "clear discarded");
        compareUnitMode <= 4'h0;
        wr(CTL, 8'h80);
        wr(HI, 8'h12);
        wr(LO, 8'h34);
        wr(CTL, 8'h00);
        rd(HI);
        chk(rv, 8'h12, 8'h12, "wide write loads high");
        wr(CTL, 8'h80);
        wr(HI, 8'h99);
        rd(LO);
        chk(rv, 8'h34, 8'h34, "wide low read");
        rd(HI);
        chk(rv, 8'h12, 8'h12, "low read latches live high");
        timer1Count <= 16'hABCD;
        for (int s = 0; s < 4; s++) begin
            wr(CTL, 8'(((s & 2) << 5) | ((s & 1) << 3)));
            chk(compare1Timebase, s[1] ? 16'h1234 : 16'hABCD, s[1] ? 16'h1234 : 16'hABCD, "unit one");
            chk(compare2Timebase, s > 0 ? 16'h1234 : 16'hABCD, s > 0 ? 16'h1234 : 16'hABCD, "unit two");
        end
        portDirectionBits <= 2'b01;
        wr(T1C, 8'h00);
        chk(oscPinInputForce, 1, 1, "pins follow direction");
        wr(T1C, 8'h08);
        chk(oscPinInputForce, 3, 3, "pins forced to inputs");
        // pin synced, pin raw, oscillator enabled, oscillator disabled
        for (int m = 0; m < 4; m++) begin
            wr(CTL, 8'h00);
            wr(LO, 8'h00);
            wr(HI, 8'h00);
            wr(T1C, m == 2 ? 8'h08 : 8'h00);
            wr(CTL, m == 1 ? 8'h07 : 8'h03);
            partner.burst(10, m >= 2);
            repeat (4) @(posedge core_clk);
            wr(CTL, 8'h00);
            rd(LO);
            // line idles low, so the first rise is not counted; its fall arms the edge detector
            chk(rv, m == 3 ? 0 : 9, m == 3 ? 0 : 9, "external edges");
        end
        wrap_up();
    end
endmodule
